/* File: hdl/pfs_regs.vh */
// Constants for the power converter fault status register group
`ifndef PFS_REGS_VH
`define PFS_REGS_VH

// Command codes of the four status registers
`define PFS_CMD_INPUT      8'h7c
`define PFS_CMD_TEMP       8'h7d
`define PFS_CMD_COMM       8'h7e
`define PFS_CMD_VENDOR     8'h80

// Input status fields
`define PFS_IN_LOW_VIN     3
`define PFS_IN_RESET       8'h08
`define PFS_IN_USED        8'h08
`define PFS_IN_LOW_VIN_RST 1'b1

// Temperature status fields
`define PFS_TMP_FAULT      7
`define PFS_TMP_WARN       6
`define PFS_TMP_USED       8'hc0

// Communication status fields
`define PFS_COM_BAD_CMD    7
`define PFS_COM_BAD_DATA   6
`define PFS_COM_PEC        5
`define PFS_COM_MEM        4
`define PFS_COM_OTHER      1
`define PFS_COM_USED       8'hf2

// Vendor status fields
`define PFS_VND_SHUTDOWN   7
`define PFS_VND_FSM_ZERO   6
`define PFS_VND_FSM_MULTI  5
`define PFS_VND_VOLTAGE_SELECT_STRAP_FAIL  4
`define PFS_VND_SS_FAIL    3
`define PFS_VND_RESET_VOUT 2
`define PFS_VND_FOLLOWER   1
`define PFS_VND_SYNC_FLT   0
`define PFS_VND_WRITABLE   8'h98
`define PFS_VND_ALERT      8'h90

// Temperature hysteresis in degrees C, and widths
`define PFS_TEMP_HYST_C    10'd20
`define PFS_TEMP_W         10
`define PFS_FSM_W          8

`endif

/* File: hdl/pfs_sync3.v */
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module pfs_sync3 (
  input  wire sys_clk_in,
  input  wire rst_in,
  input  wire ce_in,
  input  wire async_in,
  output reg  level_out
);

  reg s1_r;
  reg s2_r;
  reg s3_r;

  // All stages and the output read low under reset; invert at the caller for a high idle level
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_r      <= 1'b0;
      s2_r      <= 1'b0;
      s3_r      <= 1'b0;
      level_out <= 1'b0;
    end else if (ce_in) begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_out <= s3_r;
      end
    end
  end

endmodule

/* File: hdl/pfs_status_regs.v */
// Fault status register group: input, temperature, communication and vendor status bytes
`timescale 1ns/1ns
`include "pfs_regs.vh"
module pfs_status_regs (
  input  wire                   sys_clk_in,
  input  wire                   rst_in,
  input  wire                   ce_in,
  // Command port from the bus front end
  input  wire                   cmd_valid_in,
  input  wire                   cmd_write_in,
  input  wire [7:0]             cmd_code_in,
  input  wire [7:0]             cmd_wdata_in,
  input  wire                   clear_faults_in,
  output reg  [7:0]             rdata_out,
  output reg                    rdata_valid_out,
  output wire                   cmd_hit_out,
  // Alert mask bits from nonvolatile store, one per flag position
  input  wire [7:0]             mask_input_in,
  input  wire [7:0]             mask_temp_in,
  input  wire [7:0]             mask_comm_in,
  input  wire [7:0]             mask_vendor_in,
  // Analog comparators and pins
  input  wire                   supply_above_on_in,
  input  wire                   supply_below_off_in,
  input  wire                   bandgap_overtemp_in,
  input  wire                   output_reset_pin_n_in,
  input  wire                   sync_fault_in,
  // Same-clock logic
  input  wire [`PFS_TEMP_W-1:0] ext_temp_in,
  input  wire [`PFS_TEMP_W-1:0] overtemp_fault_threshold_in,
  input  wire [`PFS_TEMP_W-1:0] overtemp_warning_threshold_in,
  input  wire                   bad_cmd_in,
  input  wire                   bad_data_in,
  input  wire                   pec_err_in,
  input  wire                   mem_fault_in,
  input  wire                   other_comm_in,
  input  wire [`PFS_FSM_W-1:0]  op_fsm_state_in,
  input  wire                   voltage_select_strap_strap_fail_in,
  input  wire                   softstart_strap_fail_in,
  input  wire                   boot_vout_req_in,
  input  wire                   loop_follower_in,
  input  wire                   drive_on_strap_fail_enable_in,
  // Results
  output wire                   alert_out,
  output wire                   input_summary_out,
  output wire                   vendor_summary_out,
  output wire                   drive_enable_out
);

  //****************************************************************
  // Pin synchronisers
  //****************************************************************
  wire above_on_s;
  wire below_off_s;
  wire bg_ot_s;
  wire rst_pin_n_s;
  wire sync_flt_s;

  pfs_sync3 u_sync_on (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .async_in   (supply_above_on_in),
    .level_out  (above_on_s)
  );

  pfs_sync3 u_sync_off (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .async_in   (supply_below_off_in),
    .level_out  (below_off_s)
  );

  pfs_sync3 u_sync_bg (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .async_in   (bandgap_overtemp_in),
    .level_out  (bg_ot_s)
  );

  // Inverted through the synchroniser so reset shows the pin as high
  wire rst_pin_s;

  pfs_sync3 u_sync_rst (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .async_in   (~output_reset_pin_n_in),
    .level_out  (rst_pin_s)
  );

  assign rst_pin_n_s = ~rst_pin_s;

  pfs_sync3 u_sync_flt (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .async_in   (sync_fault_in),
    .level_out  (sync_flt_s)
  );

  //****************************************************************
  // Command decode
  //****************************************************************
  wire sel_in  = (cmd_code_in == `PFS_CMD_INPUT);
  wire sel_tmp = (cmd_code_in == `PFS_CMD_TEMP);
  wire sel_com = (cmd_code_in == `PFS_CMD_COMM);
  wire sel_vnd = (cmd_code_in == `PFS_CMD_VENDOR);

  assign cmd_hit_out = sel_in | sel_tmp | sel_com | sel_vnd;

  wire wr = cmd_valid_in & cmd_write_in;
  // Write-one-to-clear masks; reserved and read-only positions drop out
  wire [7:0] clr_in  = (wr & sel_in)  ? (cmd_wdata_in & `PFS_IN_USED)      : 8'h00;
  wire [7:0] clr_tmp = (wr & sel_tmp) ? (cmd_wdata_in & `PFS_TMP_USED)     : 8'h00;
  wire [7:0] clr_com = (wr & sel_com) ? (cmd_wdata_in & `PFS_COM_USED)     : 8'h00;
  wire [7:0] clr_vnd = (wr & sel_vnd) ? (cmd_wdata_in & `PFS_VND_WRITABLE) : 8'h00;

  //****************************************************************
  // Input undervoltage
  //****************************************************************
  reg ever_on_r;
  reg low_vin_r;

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ever_on_r <= 1'b0;
      low_vin_r <= `PFS_IN_LOW_VIN_RST;
    end else if (ce_in) begin
      if (above_on_s) begin
        ever_on_r <= 1'b1;
      end
      if (!ever_on_r) begin
        low_vin_r <= ~above_on_s;
      end else if (below_off_s) begin
        low_vin_r <= 1'b1;
      end else if (clear_faults_in || clr_in[`PFS_IN_LOW_VIN]) begin
        low_vin_r <= 1'b0;
      end
    end
  end

  reg [7:0] input_byte;

  always @* begin
    input_byte                  = 8'h00;
    input_byte[`PFS_IN_LOW_VIN] = low_vin_r;
  end

  // Latched only once the supply has been on; before that it raises no alert
  wire in_alert = ever_on_r & low_vin_r & ~mask_input_in[`PFS_IN_LOW_VIN];

  //****************************************************************
  // External temperature
  //****************************************************************
  // Trip holds from reaching the limit until 20 C below it
  reg ot_fault_trip_r;
  reg ot_warn_trip_r;
  reg ot_fault_r;
  reg ot_warn_r;

  wire [`PFS_TEMP_W:0] temp_hys = {1'b0, ext_temp_in} + {1'b0, `PFS_TEMP_HYST_C};
  wire fault_hit  = (ext_temp_in >= overtemp_fault_threshold_in);
  wire warn_hit   = (ext_temp_in >= overtemp_warning_threshold_in);
  wire fault_cool = (temp_hys <= {1'b0, overtemp_fault_threshold_in});
  wire warn_cool  = (temp_hys <= {1'b0, overtemp_warning_threshold_in});

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ot_fault_trip_r <= 1'b0;
      ot_warn_trip_r  <= 1'b0;
      ot_fault_r      <= 1'b0;
      ot_warn_r       <= 1'b0;
    end else if (ce_in) begin
      if (fault_hit) begin
        ot_fault_trip_r <= 1'b1;
      end else if (fault_cool) begin
        ot_fault_trip_r <= 1'b0;
      end
      if (warn_hit) begin
        ot_warn_trip_r <= 1'b1;
      end else if (warn_cool) begin
        ot_warn_trip_r <= 1'b0;
      end
      if (fault_hit || ot_fault_trip_r) begin
        ot_fault_r <= 1'b1;
      end else if (clear_faults_in || clr_tmp[`PFS_TMP_FAULT]) begin
        ot_fault_r <= 1'b0;
      end
      if (warn_hit || ot_warn_trip_r) begin
        ot_warn_r <= 1'b1;
      end else if (clear_faults_in || clr_tmp[`PFS_TMP_WARN]) begin
        ot_warn_r <= 1'b0;
      end
    end
  end

  reg [7:0] temp_byte;

  always @* begin
    temp_byte                 = 8'h00;
    temp_byte[`PFS_TMP_FAULT] = ot_fault_r;
    temp_byte[`PFS_TMP_WARN]  = ot_warn_r;
  end

  //****************************************************************
  // Communication faults
  //****************************************************************
  reg  [7:0] comm_r;
  reg  [7:0] comm_set;

  always @* begin
    comm_set                    = 8'h00;
    comm_set[`PFS_COM_BAD_CMD]  = bad_cmd_in;
    comm_set[`PFS_COM_BAD_DATA] = bad_data_in;
    comm_set[`PFS_COM_PEC]      = pec_err_in;
    comm_set[`PFS_COM_MEM]      = mem_fault_in;
    comm_set[`PFS_COM_OTHER]    = other_comm_in;
  end

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      comm_r <= 8'h00;
    end else if (ce_in) begin
      // Set wins over a clear in the same cycle
      if (clear_faults_in) begin
        comm_r <= comm_set & `PFS_COM_USED;
      end else begin
        comm_r <= ((comm_r & ~clr_com) | comm_set) & `PFS_COM_USED;
      end
    end
  end

  //****************************************************************
  // Vendor specific
  //****************************************************************
  reg shutdown_r;
  reg fsm_zero_r;
  reg fsm_multi_hot_flag_r;
  reg voltage_select_strap_strap_fail_flag_r;
  reg softstart_strap_fail_flag_r;

  wire fsm_zero = (op_fsm_state_in == {`PFS_FSM_W{1'b0}});
  wire fsm_multi = ((op_fsm_state_in & (op_fsm_state_in - 1'b1)) != {`PFS_FSM_W{1'b0}});
  wire clr_all = clear_faults_in;

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      shutdown_r                  <= 1'b0;
      fsm_zero_r                  <= 1'b0;
      fsm_multi_hot_flag_r        <= 1'b0;
      voltage_select_strap_strap_fail_flag_r      <= 1'b0;
      softstart_strap_fail_flag_r <= 1'b0;
    end else if (ce_in) begin
      if (bg_ot_s) begin
        shutdown_r <= 1'b1;
      end else if (clr_all || clr_vnd[`PFS_VND_SHUTDOWN]) begin
        shutdown_r <= 1'b0;
      end
      if (fsm_zero) begin
        fsm_zero_r <= 1'b1;
      end else if (clr_all) begin
        fsm_zero_r <= 1'b0;
      end
      if (fsm_multi) begin
        fsm_multi_hot_flag_r <= 1'b1;
      end else if (clr_all) begin
        fsm_multi_hot_flag_r <= 1'b0;
      end
      if (loop_follower_in) begin
        voltage_select_strap_strap_fail_flag_r <= 1'b0;
      end else if (voltage_select_strap_strap_fail_in) begin
        voltage_select_strap_strap_fail_flag_r <= 1'b1;
      end else if (clr_all || clr_vnd[`PFS_VND_VOLTAGE_SELECT_STRAP_FAIL]) begin
        voltage_select_strap_strap_fail_flag_r <= 1'b0;
      end
      if (loop_follower_in) begin
        softstart_strap_fail_flag_r <= 1'b0;
      end else if (softstart_strap_fail_in) begin
        softstart_strap_fail_flag_r <= 1'b1;
      end else if (clr_all || clr_vnd[`PFS_VND_SS_FAIL]) begin
        softstart_strap_fail_flag_r <= 1'b0;
      end
    end
  end

  wire reset_vout_live = ~rst_pin_n_s & boot_vout_req_in;

  reg [7:0] vendor_byte;

  always @* begin
    vendor_byte                      = 8'h00;
    vendor_byte[`PFS_VND_SHUTDOWN]   = shutdown_r;
    vendor_byte[`PFS_VND_FSM_ZERO]   = fsm_zero_r;
    vendor_byte[`PFS_VND_FSM_MULTI]  = fsm_multi_hot_flag_r;
    vendor_byte[`PFS_VND_VOLTAGE_SELECT_STRAP_FAIL]  = voltage_select_strap_strap_fail_flag_r;
    vendor_byte[`PFS_VND_SS_FAIL]    = softstart_strap_fail_flag_r;
    vendor_byte[`PFS_VND_RESET_VOUT] = reset_vout_live;
    vendor_byte[`PFS_VND_FOLLOWER]   = loop_follower_in;
    vendor_byte[`PFS_VND_SYNC_FLT]   = sync_flt_s;
  end

  //****************************************************************
  // Read path
  //****************************************************************
  reg [7:0] rdata_nxt;

  always @* begin
    case (cmd_code_in)
      `PFS_CMD_INPUT:  rdata_nxt = input_byte;
      `PFS_CMD_TEMP:   rdata_nxt = temp_byte;
      `PFS_CMD_COMM:   rdata_nxt = comm_r;
      `PFS_CMD_VENDOR: rdata_nxt = vendor_byte;
      default:         rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out       <= 8'h00;
      rdata_valid_out <= 1'b0;
    end else if (ce_in) begin
      rdata_valid_out <= cmd_valid_in & ~cmd_write_in;
      if (cmd_valid_in && !cmd_write_in) begin
        rdata_out <= rdata_nxt;
      end
    end
  end

  //****************************************************************
  // Summary bits, alert and drive enable
  //****************************************************************
  assign input_summary_out  = low_vin_r;
  assign vendor_summary_out = shutdown_r | voltage_select_strap_strap_fail_flag_r;

  wire tmp_alert = |(temp_byte & ~mask_temp_in);
  wire com_alert = |(comm_r & ~mask_comm_in);
  wire vnd_alert = |(vendor_byte & `PFS_VND_ALERT & ~mask_vendor_in);

  assign alert_out = in_alert | tmp_alert | com_alert | vnd_alert;

  // Master with a failed voltage strap stays off unless the drive option is set
  assign drive_enable_out = loop_follower_in | ~voltage_select_strap_strap_fail_flag_r | drive_on_strap_fail_enable_in;

endmodule

/* File: test/pfs_status_regs_sva.sv */
// Assertion checker for the fault status register group
`timescale 1ns/1ns
`include "pfs_regs.vh"
module pfs_sva_chk (
  input logic       sys_clk_in,
  input logic       rst_in,
  input logic       ce_in,
  input logic       cmd_valid_in,
  input logic       cmd_write_in,
  input logic [7:0] cmd_code_in,
  input logic       clear_faults_in,
  input logic [7:0] rdata_out,
  input logic       rdata_valid_out,
  input logic       cmd_hit_out,
  input logic [7:0] mask_input_in,
  input logic [7:0] mask_temp_in,
  input logic [7:0] mask_comm_in,
  input logic [7:0] mask_vendor_in,
  input logic [9:0] ext_temp_in,
  input logic [9:0] overtemp_fault_threshold_in,
  input logic       bad_cmd_in,
  input logic       loop_follower_in,
  input logic       drive_on_strap_fail_enable_in,
  input logic       alert_out,
  input logic       drive_enable_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  wire rd  = ce_in && cmd_valid_in && !cmd_write_in;
  wire hot = ext_temp_in >= overtemp_fault_threshold_in;
  a_read_answer: assert property (rd |=> rdata_valid_out)
    else $error("read not answered");
  a_valid_cause: assert property (rdata_valid_out |-> $past(rd))
    else $error("read data valid without a read");
  a_unknown_zero: assert property (rd && !cmd_hit_out |=> rdata_out == 8'h00)
    else $error("unknown code reads nonzero");
  a_hit_decode: assert property (cmd_hit_out == (cmd_code_in == `PFS_CMD_INPUT || cmd_code_in == `PFS_CMD_TEMP
    || cmd_code_in == `PFS_CMD_COMM || cmd_code_in == `PFS_CMD_VENDOR))
    else $error("command decode wrong");
  a_input_reserved: assert property (rd && cmd_code_in == `PFS_CMD_INPUT |=> (rdata_out & 8'hf7) == 8'h00)
    else $error("input reserved bits nonzero");
  a_comm_reserved: assert property (rd && cmd_code_in == `PFS_CMD_COMM |=> (rdata_out & 8'h0d) == 8'h00)
    else $error("comm reserved bits nonzero");
  a_mask_quiet: assert property (&{mask_input_in, mask_temp_in, mask_comm_in, mask_vendor_in} |-> !alert_out)
    else $error("alert with all flags masked");
  a_temp_fault: assert property (ce_in && hot ##1 rd && hot && cmd_code_in == `PFS_CMD_TEMP |=> rdata_out[7])
    else $error("fault temperature not flagged");
  a_bad_cmd_set: assert property (ce_in && bad_cmd_in ##1 !cmd_valid_in && !clear_faults_in
    ##1 rd && !clear_faults_in && cmd_code_in == `PFS_CMD_COMM |=> rdata_out[7])
    else $error("bad command not flagged");
  a_drive_option: assert property (loop_follower_in || drive_on_strap_fail_enable_in |-> drive_enable_out)
    else $error("drive disabled despite option");
  a_follower_bits: assert property (loop_follower_in ##1 rd && loop_follower_in
    && cmd_code_in == `PFS_CMD_VENDOR |=> rdata_out[4:3] == 2'b00 && rdata_out[1])
    else $error("follower vendor bits wrong");
  c_vendor_read: cover property (rd && cmd_code_in == `PFS_CMD_VENDOR);
  c_alert_rise: cover property ($rose(alert_out));
  c_unknown_read: cover property (rd && !cmd_hit_out);
endmodule
bind pfs_status_regs pfs_sva_chk chk_u (.sys_clk_in, .rst_in, .ce_in, .cmd_valid_in, .cmd_write_in, .cmd_code_in,
  .clear_faults_in, .rdata_out, .rdata_valid_out, .cmd_hit_out, .mask_input_in, .mask_temp_in, .mask_comm_in,
  .mask_vendor_in, .ext_temp_in, .overtemp_fault_threshold_in, .bad_cmd_in, .loop_follower_in,
  .drive_on_strap_fail_enable_in, .alert_out, .drive_enable_out);

/* File: test/pfs_host_model.sv */
// Host controller model issuing status reads, flag writes and clear-faults
`timescale 1ns/1ns
module pfs_host_model (
  input  logic       sys_clk_in,
  input  logic [7:0] rdata_in,
  input  logic       rdata_valid_in,
  output logic       cmd_valid_out = 1'b0,
  output logic       cmd_write_out = 1'b0,
  output logic [7:0] cmd_code_out = 8'h00,
  output logic [7:0] cmd_wdata_out = 8'h00,
  output logic       clear_faults_out = 1'b0
);
  // Idle code shows the inverse of the last value; only a write also inverts the idle data
  task automatic rd(input logic [7:0] code, output logic [7:0] d, output logic ok);
    int n;
    ok = 1'b0;
    d = 8'h00;
    @(posedge sys_clk_in);
    cmd_valid_out <= 1'b1;
    cmd_write_out <= 1'b0;
    cmd_code_out <= code;
    @(posedge sys_clk_in);
    cmd_valid_out <= 1'b0;
    cmd_code_out <= ~code;
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      if (rdata_valid_in === 1'b1) begin
        ok = 1'b1;
        d = rdata_in;
      end else begin
        @(posedge sys_clk_in);
      end
    end
  endtask
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(posedge sys_clk_in);
    cmd_valid_out <= 1'b1;
    cmd_write_out <= 1'b1;
    cmd_code_out <= code;
    cmd_wdata_out <= data;
    @(posedge sys_clk_in);
    cmd_valid_out <= 1'b0;
    cmd_write_out <= 1'b0;
    cmd_code_out <= ~code;
    cmd_wdata_out <= ~data;
  endtask
  task automatic clr;
    @(posedge sys_clk_in);
    clear_faults_out <= 1'b1;
    @(posedge sys_clk_in);
    clear_faults_out <= 1'b0;
  endtask
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the fault status register group
`timescale 1ns/1ns
`include "pfs_regs.vh"
module testbench;
  logic       sys_clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       ce_in = 1'b1;
  logic       cmd_valid_in, cmd_write_in, clear_faults_in, rdata_valid_out, cmd_hit_out;
  logic [7:0] cmd_code_in, cmd_wdata_in, rdata_out;
  logic [7:0] mask_input_in = 8'h00, mask_temp_in = 8'h00, mask_comm_in = 8'h00, mask_vendor_in = 8'h00;
  logic       supply_above_on_in = 1'b0, supply_below_off_in = 1'b1, bandgap_overtemp_in = 1'b0;
  logic       output_reset_pin_n_in = 1'b1, sync_fault_in = 1'b0, boot_vout_req_in = 1'b0;
  logic       voltage_select_strap_strap_fail_in = 1'b0, softstart_strap_fail_in = 1'b0, loop_follower_in = 1'b0;
  logic       drive_on_strap_fail_enable_in = 1'b0, alert_out, input_summary_out, vendor_summary_out;
  logic       drive_enable_out;
  logic [9:0] ext_temp_in = 10'h000, overtemp_fault_threshold_in = 10'h3ff, overtemp_warning_threshold_in = 10'h3ff;
  logic [7:0] op_fsm_state_in = 8'h01;
  logic [4:0] comm_ev = 5'h00;
  logic [7:0] bl [5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h02};
  int         err_count = 0, samples_checked = 0, b, f, w, tl [5];

  always #5 sys_clk_in = ~sys_clk_in;

  pfs_status_regs dut_u (.sys_clk_in, .rst_in, .ce_in, .cmd_valid_in, .cmd_write_in, .cmd_code_in, .cmd_wdata_in,
    .clear_faults_in, .rdata_out, .rdata_valid_out, .cmd_hit_out, .mask_input_in, .mask_temp_in, .mask_comm_in,
    .mask_vendor_in, .supply_above_on_in, .supply_below_off_in, .bandgap_overtemp_in, .output_reset_pin_n_in,
    .sync_fault_in, .ext_temp_in, .overtemp_fault_threshold_in, .overtemp_warning_threshold_in,
    .bad_cmd_in(comm_ev[4]), .bad_data_in(comm_ev[3]), .pec_err_in(comm_ev[2]), .mem_fault_in(comm_ev[1]),
    .other_comm_in(comm_ev[0]), .op_fsm_state_in, .voltage_select_strap_strap_fail_in, .softstart_strap_fail_in,
    .boot_vout_req_in, .loop_follower_in, .drive_on_strap_fail_enable_in, .alert_out, .input_summary_out,
    .vendor_summary_out, .drive_enable_out);
  pfs_host_model host_u (.sys_clk_in, .rdata_in(rdata_out), .rdata_valid_in(rdata_valid_out),
    .cmd_valid_out(cmd_valid_in), .cmd_write_out(cmd_write_in), .cmd_code_out(cmd_code_in),
    .cmd_wdata_out(cmd_wdata_in), .clear_faults_out(clear_faults_in));

  // Flags after a host clear: set again until temperature is 20 below the limit
  function automatic logic [7:0] tmp_exp(input int t, input int fl, input int wl);
    return {t > fl - 20, t > wl - 20, 6'h00};
  endfunction
  task chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task chk1(input logic s, input logic e);
    chk({7'h00, s}, {7'h00, e});
  endtask
  task rd_chk(input logic [7:0] code, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    host_u.rd(code, d, ok);
    if (ok !== 1'b1) begin
      err_count++;
      end_of_test();
    end else begin
      chk(d, e);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  task end_of_test;
    $display("errors %0d, checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(76));
    step(8);
    rst_in <= 1'b0;
    rd_chk(`PFS_CMD_INPUT, 8'h08);
    rd_chk(`PFS_CMD_TEMP, 8'h00);
    rd_chk(8'h7f, 8'h00);
    host_u.wr(`PFS_CMD_INPUT, 8'hff);
    rd_chk(`PFS_CMD_INPUT, 8'h08);
    chk1(alert_out, 1'b0);
    chk1(input_summary_out, 1'b1);
    step(1);
    supply_above_on_in <= 1'b1;
    supply_below_off_in <= 1'b0;
    step(6);
    rd_chk(`PFS_CMD_INPUT, 8'h00);
    step(1);
    supply_above_on_in <= 1'b0;
    supply_below_off_in <= 1'b1;
    step(6);
    supply_above_on_in <= 1'b1;
    supply_below_off_in <= 1'b0;
    step(6);
    rd_chk(`PFS_CMD_INPUT, 8'h08);
    chk1(alert_out, 1'b1);
    step(1);
    {mask_input_in, mask_temp_in, mask_comm_in, mask_vendor_in} <= 32'hffff_ffff;
    #1 chk1(alert_out, 1'b0);
    step(1);
    {mask_input_in, mask_temp_in, mask_comm_in, mask_vendor_in} <= 32'h0800_0000;
    #1 chk1(alert_out, 1'b0);
    host_u.wr(`PFS_CMD_INPUT, 8'h08);
    rd_chk(`PFS_CMD_INPUT, 8'h00);
    chk1(input_summary_out, 1'b0);
    for (b = 0; b < 5; b++) begin
      step(1);
      mask_input_in <= 8'h00;
      comm_ev <= 5'h10 >> b;
      step(1);
      comm_ev <= 5'h00;
      rd_chk(`PFS_CMD_COMM, bl[b]);
      chk1(alert_out, 1'b1);
      host_u.wr(`PFS_CMD_COMM, 8'($urandom) & ~bl[b]);
      rd_chk(`PFS_CMD_COMM, bl[b]);
      step(1);
      mask_comm_in <= bl[b];
      #1 chk1(alert_out, 1'b0);
      host_u.wr(`PFS_CMD_COMM, 8'($urandom) | bl[b]);
      rd_chk(`PFS_CMD_COMM, 8'h00);
      step(1);
      mask_comm_in <= 8'h00;
    end
    ce_in <= 1'b0;
    comm_ev <= 5'h1f;
    step(1);
    ce_in <= 1'b1;
    comm_ev <= 5'h00;
    rd_chk(`PFS_CMD_COMM, 8'h00);
    step(1);
    f = 200 + $urandom % 100;
    w = f - 60;
    tl = '{f, f - 19, f - 20, w - 19, w - 20};
    overtemp_fault_threshold_in <= 10'(f);
    overtemp_warning_threshold_in <= 10'(w);
    ext_temp_in <= 10'(f);
    rd_chk(`PFS_CMD_TEMP, 8'hc0);
    for (b = 0; b < 5; b++) begin
      step(1);
      ext_temp_in <= 10'(tl[b]);
      host_u.wr(`PFS_CMD_TEMP, 8'hff);
      rd_chk(`PFS_CMD_TEMP, tmp_exp(tl[b], f, w));
    end
    step(1);
    bandgap_overtemp_in <= 1'b1;
    op_fsm_state_in <= 8'h00;
    output_reset_pin_n_in <= 1'b0;
    boot_vout_req_in <= 1'b1;
    sync_fault_in <= 1'b1;
    voltage_select_strap_strap_fail_in <= 1'b1;
    softstart_strap_fail_in <= 1'b1;
    step(1);
    voltage_select_strap_strap_fail_in <= 1'b0;
    softstart_strap_fail_in <= 1'b0;
    op_fsm_state_in <= 8'h03;
    step(6);
    rd_chk(`PFS_CMD_VENDOR, 8'hfd);
    chk1(vendor_summary_out, 1'b1);
    chk1(drive_enable_out, 1'b0);
    step(1);
    mask_vendor_in <= 8'h90;
    #1 chk1(alert_out, 1'b0);
    step(1);
    mask_vendor_in <= 8'h80;
    drive_on_strap_fail_enable_in <= 1'b1;
    #1 chk1(alert_out, 1'b1);
    chk1(drive_enable_out, 1'b1);
    step(1);
    loop_follower_in <= 1'b1;
    rd_chk(`PFS_CMD_VENDOR, 8'he7);
    step(1);
    loop_follower_in <= 1'b0;
    bandgap_overtemp_in <= 1'b0;
    output_reset_pin_n_in <= 1'b1;
    boot_vout_req_in <= 1'b0;
    sync_fault_in <= 1'b0;
    op_fsm_state_in <= 8'h01;
    voltage_select_strap_strap_fail_in <= 1'b1;
    step(1);
    voltage_select_strap_strap_fail_in <= 1'b0;
    drive_on_strap_fail_enable_in <= 1'b0;
    step(6);
    host_u.wr(`PFS_CMD_VENDOR, 8'hff);
    rd_chk(`PFS_CMD_VENDOR, 8'h60);
    host_u.clr();
    rd_chk(`PFS_CMD_VENDOR, 8'h00);
    chk1(vendor_summary_out, 1'b0);
    chk1(drive_enable_out, 1'b1);
    end_of_test();
  end
endmodule
